//--- inc/ilb_pkg.sv
// Purpose: Shared constants and types for the interrupt latch bit update block.
// Assumes: One core clock; all latch registers are 32 bits wide.
// Notes: Bit positions of the interrupt sources are fixed here and used by the core logic.
//
// Contract
// - Bit set, clear and toggle with a 32-bit mask act on the latch, secondary latch and mask pointer registers.
// - The execute phase stretches while any core hold-off cause is active.
// - External request lines, emulator, both timer, vector, link port, serial and port DMA interrupts latch here.
// - Link port and serial peripheral interrupts latch only while their unit runs in DMA mode.
// - An instruction fetched and executed from external memory is a context where events could be lost.
// - An instruction in a delay slot of a branch into external memory is such a context.
// - An instruction immediately followed by an external data or program memory access is such a context.
// - An instruction issued from the emulator, running or stepping, is such a context.
// - An internal instruction immediately followed by a breakpoint register access is such a context.
package ilb_pkg;

  localparam int ILB_W = 32;
  localparam int ILB_NREG = 3;
  localparam int ILB_NIRQ = 3;
  localparam int ILB_NLINK = 2;
  localparam int ILB_NEP = 4;

  // ****************************************************************
  // Register reset values
  // ****************************************************************
  localparam logic [31:0] ILB_LATCH_RST = 32'h0000_0000;
  localparam logic [31:0] ILB_SEC_RST = 32'h0000_0000;
  localparam logic [31:0] ILB_MASKP_RST = 32'h0000_0000;

  // ****************************************************************
  // Source bit positions
  // ****************************************************************
  localparam int ILB_POS_EMU = 1;
  localparam int ILB_POS_TMR_HI = 4;
  localparam int ILB_POS_IRQ0 = 8;
  localparam int ILB_POS_TMR_LO = 19;
  localparam int ILB_POS_VEC = 20;
  localparam int ILB_POS_LINK0 = 0;
  localparam int ILB_POS_SPI_RX = 2;
  localparam int ILB_POS_SPI_TX = 3;
  localparam int ILB_POS_EP0 = 4;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [2:0] {
    ILB_OP_SET = 3'h1,
    ILB_OP_CLR = 3'h2,
    ILB_OP_TGL = 3'h4
  } ilb_op_t;

  // Target select with one bit per register, any combination allowed; bit index equals register index.
  localparam int ILB_TGT_LATCH = 0;
  localparam int ILB_TGT_SEC = 1;
  localparam int ILB_TGT_MASKP = 2;

  typedef enum logic [1:0] {
    ILB_ST_IDLE = 2'h1,
    ILB_ST_EXEC = 2'h2
  } ilb_state_t;

endpackage

//--- verilog/ilb_bitop.sv
// Purpose: Next value of one latch register for a bit set, clear or toggle.
// Assumes: Events are one-cycle pulses on the core clock.
// Notes: Purely combinational; new events always survive the operation.
module ilb_bitop
  import ilb_pkg::*;
(
  input wire logic [31:0] cur,
  input wire logic [31:0] mask,
  input wire ilb_op_t op,
  input wire logic apply,
  input wire logic [31:0] events,
  output logic [31:0] next_value
);

  logic [31:0] result;

  always_comb begin
    result = cur;
    if (apply) begin
      case (op)
        ILB_OP_SET: result = cur | mask;
        ILB_OP_CLR: result = cur & ~mask;
        ILB_OP_TGL: result = cur ^ mask;
        default: result = cur;
      endcase
    end
    // An event arriving in the commit cycle wins over a clear.
    next_value = result | events;
  end

endmodule

//--- verilog/ilb_latch_update.sv
// Purpose: Interrupt latch update for bit set, clear and toggle instructions.
// Assumes: The sequencer holds its request until ready; sources other than the
//   external request pins are one-cycle pulses on the core clock.
// Notes: Events are merged every cycle, so a stretched execute phase loses none.
module ilb_latch_update
  import ilb_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic instr_valid,
  input wire ilb_op_t instr_op,
  input wire logic [2:0] instr_target,
  input wire logic [31:0] instr_mask,
  output logic instr_ready,
  input wire logic hold_ext_fetch,
  input wire logic hold_ext_data,
  input wire logic hold_buf_empty_read,
  input wire logic hold_buf_full_write,
  input wire logic hold_iop_slow_read,
  input wire logic ctx_from_ext_mem,
  input wire logic ctx_delay_slot_ext_target,
  input wire logic ctx_next_ext_access,
  input wire logic ctx_from_emulator,
  input wire logic ctx_next_bkpt_access,
  input wire logic [2:0] external_interrupt_request_lines,
  input wire logic emulator_interrupt,
  input wire logic timer_high_priority_interrupt,
  input wire logic timer_low_priority_interrupt,
  input wire logic vector_interrupt,
  input wire logic [1:0] link_port_interrupt,
  input wire logic serial_peripheral_receive_interrupt,
  input wire logic serial_peripheral_transmit_interrupt,
  input wire logic [3:0] external_port_dma_interrupt,
  input wire logic link_dma_mode,
  input wire logic serial_dma_mode,
  output logic [31:0] interrupt_latch_register,
  output logic [31:0] secondary_interrupt_latch_register,
  output logic [31:0] interrupt_mask_pointer_register,
  output logic exec_stretched,
  output logic instr_done,
  output logic hazard_context,
  output logic stretch_event_seen
);

  // ****************************************************************
  // Instruction sequencing
  // ****************************************************************
  ilb_state_t state;
  ilb_op_t op_q;
  logic [2:0] target_q;
  logic [31:0] mask_q;
  logic hold_off;
  logic commit;
  logic take;

  assign hold_off = hold_ext_fetch | hold_ext_data | hold_buf_empty_read
                    | hold_buf_full_write | hold_iop_slow_read;
  assign instr_ready = (state == ILB_ST_IDLE);
  assign take = instr_valid & instr_ready;
  assign commit = (state == ILB_ST_EXEC) & ~hold_off;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state <= ILB_ST_IDLE;
    end else begin
      case (state)
        ILB_ST_IDLE: if (take) state <= ILB_ST_EXEC;
        ILB_ST_EXEC: if (!hold_off) state <= ILB_ST_IDLE;
        default: state <= ILB_ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      op_q <= ILB_OP_SET;
      target_q <= 3'h0;
      mask_q <= 32'h0000_0000;
    end else if (take) begin
      op_q <= instr_op;
      target_q <= instr_target;
      mask_q <= instr_mask;
    end
  end

  // ****************************************************************
  // External request pin synchronisers and edge detection
  // ****************************************************************
  logic [2:0] irq_meta;
  logic [2:0] irq_sync;
  logic [2:0] irq_prev;
  logic [2:0] irq_rise;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irq_meta <= 3'h0;
      irq_sync <= 3'h0;
      irq_prev <= 3'h0;
    end else begin
      irq_meta <= external_interrupt_request_lines;
      irq_sync <= irq_meta;
      irq_prev <= irq_sync;
    end
  end

  assign irq_rise = irq_sync & ~irq_prev;

  // ****************************************************************
  // Event vectors per register
  // ****************************************************************
  logic [31:0] ev [ILB_NREG];
  logic [31:0] cur [ILB_NREG];
  logic [31:0] nxt [ILB_NREG];

  always_comb begin
    ev[ILB_TGT_LATCH] = 32'h0000_0000;
    ev[ILB_TGT_LATCH][ILB_POS_EMU] = emulator_interrupt;
    ev[ILB_TGT_LATCH][ILB_POS_TMR_HI] = timer_high_priority_interrupt;
    ev[ILB_TGT_LATCH][ILB_POS_TMR_LO] = timer_low_priority_interrupt;
    ev[ILB_TGT_LATCH][ILB_POS_VEC] = vector_interrupt;
    ev[ILB_TGT_LATCH][ILB_POS_IRQ0 +: ILB_NIRQ] = irq_rise;
    ev[ILB_TGT_SEC] = 32'h0000_0000;
    ev[ILB_TGT_SEC][ILB_POS_LINK0 +: ILB_NLINK] =
      link_port_interrupt & {ILB_NLINK{link_dma_mode}};
    ev[ILB_TGT_SEC][ILB_POS_SPI_RX] =
      serial_peripheral_receive_interrupt & serial_dma_mode;
    ev[ILB_TGT_SEC][ILB_POS_SPI_TX] =
      serial_peripheral_transmit_interrupt & serial_dma_mode;
    ev[ILB_TGT_SEC][ILB_POS_EP0 +: ILB_NEP] = external_port_dma_interrupt;
    ev[ILB_TGT_MASKP] = 32'h0000_0000;
  end

  // ****************************************************************
  // Latch registers
  // ****************************************************************
  localparam logic [31:0] RST_VAL [ILB_NREG] = '{ILB_LATCH_RST, ILB_SEC_RST, ILB_MASKP_RST};

  genvar g;
  generate
    for (g = 0; g < ILB_NREG; g++) begin : g_reg
      ilb_bitop u_bitop (
        .cur(cur[g]),
        .mask(mask_q),
        .op(op_q),
        .apply(commit & target_q[g]),
        .events(ev[g]),
        .next_value(nxt[g])
      );
    end
  endgenerate

  // Merged every cycle, including every cycle of a stretched phase.
  // One process drives the whole array so each register has a single driver.
  always_ff @(posedge clk) begin
    for (int i = 0; i < ILB_NREG; i++) begin
      if (!rst_n) begin
        cur[i] <= RST_VAL[i];
      end else begin
        cur[i] <= nxt[i];
      end
    end
  end

  assign interrupt_latch_register = cur[ILB_TGT_LATCH];
  assign secondary_interrupt_latch_register = cur[ILB_TGT_SEC];
  assign interrupt_mask_pointer_register = cur[ILB_TGT_MASKP];

  // ****************************************************************
  // Status
  // ****************************************************************
  logic ctx_hit;
  logic any_event;

  // Contexts in which the unmerged update used to drop events.
  assign ctx_hit = ctx_from_ext_mem
                   | ctx_delay_slot_ext_target
                   | ctx_next_ext_access
                   | ctx_from_emulator
                   | ctx_next_bkpt_access;
  assign any_event = |(ev[ILB_TGT_LATCH] | ev[ILB_TGT_SEC]);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      instr_done <= 1'b0;
      exec_stretched <= 1'b0;
    end else begin
      instr_done <= commit;
      exec_stretched <= (state == ILB_ST_EXEC) & hold_off;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      hazard_context <= 1'b0;
    end else if (take) begin
      hazard_context <= ctx_hit;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      stretch_event_seen <= 1'b0;
    end else if (take) begin
      stretch_event_seen <= 1'b0;
    end else if ((state == ILB_ST_EXEC) & hold_off & any_event) begin
      stretch_event_seen <= 1'b1;
    end
  end

endmodule

//--- tb/ilb_checker.sv
// Purpose: Port timing checks for the latch update block.
// Assumes: One core clock, synchronous active-low reset.
// Notes: Bound to every instance of the block.
module ilb_checker (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic instr_valid,
  input wire logic instr_ready,
  input wire logic instr_done,
  input wire logic exec_stretched,
  input wire logic hold_ext_fetch,
  input wire logic ctx_from_ext_mem,
  input wire logic hazard_context,
  input wire logic timer_high_priority_interrupt,
  input wire logic vector_interrupt,
  input wire logic [1:0] link_port_interrupt,
  input wire logic link_dma_mode,
  input wire logic [31:0] interrupt_latch_register,
  input wire logic [31:0] secondary_interrupt_latch_register
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  take_busy_a: assert property (instr_valid && instr_ready |=> !instr_ready)
    else $error("ready high after take");
  done_bound_a: assert property (instr_valid && instr_ready |-> ##[2:40] instr_done)
    else $error("no done after take");
  done_pulse_a: assert property (instr_done |=> !instr_done)
    else $error("done longer than one cycle");
  stretch_flag_a: assert property (!instr_ready && hold_ext_fetch |=> exec_stretched)
    else $error("stretch not flagged");
  timer_latch_a: assert property (timer_high_priority_interrupt |=>
    interrupt_latch_register[4]) else $error("timer event lost");
  vector_latch_a: assert property (vector_interrupt |=> interrupt_latch_register[20])
    else $error("vector event lost");
  link_refuse_a: assert property (!link_dma_mode && instr_ready && !instr_valid |=>
    $stable(secondary_interrupt_latch_register[1:0])) else $error("link event in core mode");
  link_dma_a: assert property (link_dma_mode && link_port_interrupt[0] |=>
    secondary_interrupt_latch_register[0]) else $error("link event lost");
  ctx_flag_a: assert property (instr_valid && instr_ready && ctx_from_ext_mem |=>
    hazard_context) else $error("context not flagged");
  cover property (instr_valid && instr_ready);
  cover property (exec_stretched && !instr_ready);
  cover property (vector_interrupt && !instr_ready);
endmodule

bind ilb_latch_update ilb_checker ilb_checker_inst (
  .clk(clk),
  .rst_n(rst_n),
  .instr_valid(instr_valid),
  .instr_ready(instr_ready),
  .instr_done(instr_done),
  .exec_stretched(exec_stretched),
  .hold_ext_fetch(hold_ext_fetch),
  .ctx_from_ext_mem(ctx_from_ext_mem),
  .hazard_context(hazard_context),
  .timer_high_priority_interrupt(timer_high_priority_interrupt),
  .vector_interrupt(vector_interrupt),
  .link_port_interrupt(link_port_interrupt),
  .link_dma_mode(link_dma_mode),
  .interrupt_latch_register(interrupt_latch_register),
  .secondary_interrupt_latch_register(secondary_interrupt_latch_register)
);

//--- tb/ilb_src_model.sv
// Purpose: Peripheral and pin interrupt sources.
// Assumes: Requests change on the falling edge.
// Notes: Outputs change just after the rising edge.
module ilb_src_model (
  input wire logic clk,
  input wire logic [14:0] req,
  output logic [2:0] external_interrupt_request_lines,
  output logic emulator_interrupt,
  output logic timer_high_priority_interrupt,
  output logic timer_low_priority_interrupt,
  output logic vector_interrupt,
  output logic [1:0] link_port_interrupt,
  output logic serial_peripheral_receive_interrupt,
  output logic serial_peripheral_transmit_interrupt,
  output logic [3:0] external_port_dma_interrupt
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [14:0] q;
  always_ff @(posedge clk) begin
    q <= req;
  end
  assign {external_port_dma_interrupt, serial_peripheral_transmit_interrupt,
    serial_peripheral_receive_interrupt, link_port_interrupt, vector_interrupt,
    timer_low_priority_interrupt, timer_high_priority_interrupt, emulator_interrupt,
    external_interrupt_request_lines} = q;
endmodule

//--- tb/interrupt_latch_bit_update_test.sv
// Purpose: Self-checking bench for the latch update block.
// Assumes: Inputs change on the falling clock edge.
// Notes: Hold-off causes and contexts are walked by index.
module interrupt_latch_bit_update_test import ilb_pkg::*; ();
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'h0, rst_n = 1'h0, instr_valid = 1'h0, link_dma_mode = 1'h0;
  logic serial_dma_mode = 1'h0;
  ilb_op_t instr_op = ILB_OP_SET;
  logic [2:0] instr_target = 3'h1;
  logic [31:0] instr_mask = 32'h0;
  logic [4:0] hold = 5'h0, ctx = 5'h0;
  logic [14:0] req = 15'h0;
  wire hold_ext_fetch, hold_ext_data, hold_buf_empty_read, hold_buf_full_write;
  wire hold_iop_slow_read, ctx_from_ext_mem, ctx_delay_slot_ext_target, ctx_next_ext_access;
  wire ctx_from_emulator, ctx_next_bkpt_access, emulator_interrupt, vector_interrupt;
  wire timer_high_priority_interrupt, timer_low_priority_interrupt;
  wire serial_peripheral_receive_interrupt, serial_peripheral_transmit_interrupt;
  wire instr_ready, exec_stretched, instr_done, hazard_context, stretch_event_seen;
  wire [2:0] external_interrupt_request_lines;
  wire [1:0] link_port_interrupt;
  wire [3:0] external_port_dma_interrupt;
  wire [31:0] interrupt_latch_register, secondary_interrupt_latch_register;
  wire [31:0] interrupt_mask_pointer_register;
  wire [95:0] regs = {interrupt_mask_pointer_register, secondary_interrupt_latch_register,
    interrupt_latch_register};
  int n_mismatch = 0, checked = 0;
  assign {hold_iop_slow_read, hold_buf_full_write, hold_buf_empty_read, hold_ext_data,
    hold_ext_fetch} = hold;
  assign {ctx_next_bkpt_access, ctx_from_emulator, ctx_next_ext_access,
    ctx_delay_slot_ext_target, ctx_from_ext_mem} = ctx;
  ilb_latch_update ilb_latch_update_inst (.*);
  ilb_src_model ilb_src_model_inst (.*);
  initial forever #20 clk = ~clk;
  task automatic chk(logic [31:0] seen, logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Entered at a falling edge; h cycles of hold-off cause k, events s fired after take.
  task automatic run(ilb_op_t o, logic [2:0] t, logic [31:0] m, int h, int k, logic [14:0] s);
    instr_op = o;
    instr_target = t;
    instr_mask = m;
    instr_valid = 1'h1;
    @(negedge clk);
    instr_valid = 1'h0;
    hold = (h > 0) ? 5'h1 << k : 5'h0;
    req = s;
    @(negedge clk);
    req = 15'h0;
    if (h > 0) chk(exec_stretched, 1);
    if (h > 1) repeat (h - 1) @(negedge clk);
    hold = 5'h0;
    for (int i = 0; i < 20; i++) if (instr_done !== 1'h1) @(negedge clk);
    chk(instr_done, 1);
  endtask
  task automatic complete_run();
    $display("checked=%0d n_mismatch=%0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial begin
    #40000;
    n_mismatch++;
    complete_run();
  end
  initial begin
    repeat (2) @(negedge clk);
    rst_n = 1'h1;
    chk(regs[31:0] | regs[63:32] | regs[95:64], 32'h0);
    for (int t = 0; t < 3; t++) begin
      run(ILB_OP_SET, 3'h1 << t, 32'hf0f0_0000, 0, 0, 15'h0);
      run(ILB_OP_TGL, 3'h1 << t, 32'hff00_0000, 1, t, 15'h0);
      chk(regs[t*32 +: 32], 32'h0ff0_0000);
      run(ILB_OP_CLR, 3'h1 << t, 32'hffff_ffff, 2, t + 2, 15'h0);
      chk(regs[t*32 +: 32], 32'h0);
    end
    link_dma_mode = 1'h1;
    serial_dma_mode = 1'h1;
    run(ILB_OP_SET, 3'h1, 32'h1, 3, 0, 15'h7fff);
    repeat (4) @(negedge clk);
    chk(interrupt_latch_register, 32'h0018_0713);
    chk(secondary_interrupt_latch_register, 32'hff);
    chk(stretch_event_seen, 1);
    // One hold cycle puts the timer pulse on the very edge at which the clear commits.
    run(ILB_OP_CLR, 3'h3, 32'hffff_ffff, 1, 0, 15'h0010);
    chk(interrupt_latch_register, 32'h10);
    chk(secondary_interrupt_latch_register, 32'h0);
    chk(stretch_event_seen, 0);
    link_dma_mode = 1'h0;
    serial_dma_mode = 1'h0;
    run(ILB_OP_SET, 3'h4, 32'h0, 1, 1, 15'h0780);
    chk(secondary_interrupt_latch_register, 32'h0);
    for (int k = 0; k < 5; k++) begin
      ctx = 5'h1 << k;
      run(ILB_OP_SET, 3'h4, 32'h0, 0, 0, 15'h0);
      chk(hazard_context, 1);
    end
    ctx = 5'h0;
    run(ILB_OP_SET, 3'h4, 32'h0, 0, 0, 15'h0);
    chk(hazard_context, 0);
    complete_run();
  end
endmodule
